/* File: include/apm_pkg.sv */
// Constants, types and register map of the pack/merge/float-add datapath slice.
// Assumes one AHB-Lite master, one 25 MHz clock and two compute blocks.
//
// Overview of operation
// RQ1: Widen cast: sign flag is result top bit, overflow and carry cleared, sticky kept.
// RQ2: Widen fills low zeros for fractions, zero or sign high bits for integers.
// RQ3: Narrow-pack optionally adds or subtracts second pair, then packs into one register.
// RQ4: Narrow-pack converts two words to two shorts, or four shorts to four bytes.
// RQ5: Fractional narrow keeps upper half, rounds nearest even, or truncates on option.
// RQ6: Fractional narrow saturates as signed when rounding up the largest positive value.
// RQ7: Integer narrow writes lower halves; upper bits only decide overflow.
// RQ8: Signed non-saturating narrow flags overflow when upper bits differ from sign.
// RQ9: Signed saturating narrow writes largest positive or most negative on overflow.
// RQ10: Unsigned saturating narrow overflows on any nonzero upper bit, writes all ones.
// RQ11: Narrow sets overflow when out of range or negative unsigned; carry cleared.
// RQ12: Interleave transposes bytes or shorts of two sources; zero flag on all zero.
// RQ13: Float add/sub normalizes, rounds to 32 or 40 bits, nearest or toward zero.
// RQ14: Float overflow gives signed infinity, or signed largest normal when truncating.
// RQ15: Denormal results and inputs become signed zero; any NaN gives all ones.
// RQ16: Largest normal is exponent FE with all fraction bits set, bias 127.
// RQ17: Float zero flag on zero or denormal, sign flag if negative, carry cleared.
// RQ18: Denormal float result sets sticky underflow; never cleared by the operation.
// RQ19: Float overflow sets overflow flag and sticky float overflow, sticky kept otherwise.
// RQ20: NaN input or invalid infinity pairing sets invalid flag and sticky invalid.
// RQ21: Halved float add/sub decrements exponent before rounding, else same as adder.
// RQ22: Each operation runs in block X, block Y or both; flags per block.
// RQ23: Integer narrow without saturation keeps truncated halves even when overflow raised.
package apm_pkg;

  localparam int          DATA_W     = 32;
  localparam int          DWORD_W    = 64;
  localparam int          QUAD_W     = 128;
  localparam int          BYTE_W     = 8;
  localparam int          SHORT_W    = 16;
  localparam int          MAX_ELEMS  = 8;
  localparam int          ADDR_W     = 8;
  localparam int          FP_SUM_W   = 36;
  localparam int          FP_EXT_W   = 8;

  // Register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_BLK_X = 8'h40;
  localparam logic [7:0]  ADDR_BLK_Y = 8'h80;
  localparam logic [7:0]  BLK_MASK   = 8'hc0;
  localparam logic [7:0]  ALIGN_MASK = 8'h03;
  localparam logic [3:0]  WORD_OPA0  = 4'h0;
  localparam logic [3:0]  WORD_OPA1  = 4'h1;
  localparam logic [3:0]  WORD_OPB0  = 4'h2;
  localparam logic [3:0]  WORD_OPB1  = 4'h3;
  localparam logic [3:0]  WORD_RES0  = 4'h4;
  localparam logic [3:0]  WORD_RES1  = 4'h5;
  localparam logic [3:0]  WORD_RES2  = 4'h6;
  localparam logic [3:0]  WORD_RES3  = 4'h7;
  localparam logic [3:0]  WORD_STAT  = 4'h8;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  // Element number formats
  localparam logic [1:0]  MODE_FRAC                      = 2'h0;
  localparam logic [1:0]  MODE_SIGNED_INT                = 2'h1;
  localparam logic [1:0]  MODE_SIGNED_SATURATING_INT     = 2'h2;
  localparam logic [1:0]  MODE_UNSIGNED_SATURATING_INT   = 2'h3;
  localparam logic [1:0]  MODE_UNSIGNED_INT_NO_SAT       = 2'h3;

  // Single-precision fields
  localparam logic [7:0]  FP_EXP_ZERO    = 8'h00;
  localparam logic [7:0]  FP_EXP_MAX     = 8'hff;
  localparam logic [7:0]  FP_EXP_LARGEST = 8'hfe;
  localparam logic signed [10:0] FP_E_OVF = 11'sh0ff;
  localparam logic signed [10:0] FP_E_MIN = 11'sh000;

  typedef enum logic [2:0] {
    APM_OP_NONE,
    APM_OP_EXPAND,
    APM_OP_COMPACT,
    APM_OP_MERGE,
    APM_OP_FADD,
    APM_OP_FHALF
  } apm_op_t;

  typedef struct packed {
    logic [1:0] blk_sel;
    logic       trunc;
    logic       use_rn;
    logic       sub;
    logic       quad;
    logic       elem_byte;
    logic [1:0] mode;
    apm_op_t    op;
  } apm_ctrl_t;

  typedef struct packed {
    logic sticky_invalid;
    logic invalid_flag;
    logic sticky_float_overflow;
    logic sticky_underflow;
    logic carry_flag;
    logic sticky_fixed_overflow;
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
  } apm_stat_t;

  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [22:0] frac;
  } apm_float_t;

  typedef struct packed {
    logic [1:0][31:0] w;
    logic             zero;
    logic             ovf;
    logic             unf;
    logic             inv;
  } apm_fp_t;

  typedef struct packed {
    logic [3:0][31:0] data;
    apm_stat_t        stat;
  } apm_result_t;

  typedef struct packed {
    logic       hit;
    logic       blk;
    logic [3:0] word;
  } apm_dec_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } apm_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } apm_ahb_rsp_t;

  localparam int CTRL_W = $bits(apm_ctrl_t);
  localparam int STAT_W = $bits(apm_stat_t);

endpackage : apm_pkg

/* File: core/apm_core.sv */
// Pack, interleave and float add datapath for two compute blocks, AHB-Lite slave.
// Assumes a single-master bus whose hready is this slave's hreadyout.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
module apm_core (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire apm_pkg::apm_ahb_req_t ahb_req,
  output      apm_pkg::apm_ahb_rsp_t ahb_rsp
);
  import apm_pkg::*;

  function automatic apm_dec_t apm_decode(input logic [7:0] addr);
    apm_dec_t d;
    d.blk  = ((addr & BLK_MASK) == ADDR_BLK_Y);
    d.word = addr[5:2];
    d.hit  = (((addr & BLK_MASK) == ADDR_BLK_X) || d.blk) && ((addr & ALIGN_MASK) == '0) &&
             (d.word <= WORD_STAT);
    return d;
  endfunction : apm_decode

  function automatic logic [31:0] apm_widen(input logic [31:0] x, input int nw,
                                            input logic [1:0] mode);
    logic [31:0] lo_mask;
    lo_mask = (32'h1 << nw) - 32'h1;
    if (mode == MODE_FRAC) return x << nw;                  // [RQ2]
    if (mode == MODE_UNSIGNED_INT_NO_SAT) return x & lo_mask;  // [RQ2]
    return x[nw-1] ? (x | ~lo_mask) : (x & lo_mask);        // [RQ2]
  endfunction : apm_widen

  function automatic logic signed [33:0] apm_ext34(input logic [31:0] x, input int w,
                                                   input logic uns);
    logic [33:0] m;
    m = (34'h1 << w) - 34'h1;
    if (uns || !x[w-1]) return 34'(x) & m;
    return 34'(x) | ~m;
  endfunction : apm_ext34

  // Returns {overflow, packed element}; element bits above h are don't care
  function automatic logic [16:0] apm_narrow(input logic signed [33:0] v, input int h,
                                             input logic [1:0] mode, input logic trunc);
    logic signed [33:0] one;
    logic signed [33:0] smax;
    logic signed [33:0] smin;
    logic signed [33:0] umax;
    logic signed [33:0] q;
    logic signed [33:0] rem;
    logic signed [33:0] half;
    logic               ov;
    one  = 34'sh1;
    smax = (one <<< (h - 1)) - one;
    smin = -(one <<< (h - 1));
    umax = (one <<< h) - one;
    rem  = '0;
    half = one <<< (h - 1);
    ov   = 1'b0;
    q    = v;
    case (mode)
      MODE_FRAC: begin
        q   = v >>> h;                                                  // [RQ5]
        rem = v - (q <<< h);
        if (!trunc && ((rem > half) || ((rem == half) && q[0]))) q = q + one;  // [RQ5]
        // Only a round-up of the top value or an add/sub can leave the range
        if (q > smax) begin                                             // [RQ6]
          ov = 1'b1;
          q  = smax;
        end else if (q < smin) begin
          ov = 1'b1;
          q  = smin;
        end
      end
      MODE_SIGNED_INT: ov = (v > smax) || (v < smin);            // [RQ7] [RQ8] [RQ23]
      MODE_SIGNED_SATURATING_INT: begin
        ov = (v > smax) || (v < smin);                                  // [RQ9]
        if (ov) q = (v < 34'sh0) ? smin : smax;                         // [RQ9]
      end
      default: begin
        ov = (v < 34'sh0) || (v > umax);                                // [RQ10] [RQ11]
        if (ov) q = umax;                                               // [RQ10]
      end
    endcase
    return {ov, q[15:0]};
  endfunction : apm_narrow

  function automatic int apm_lzc(input logic [35:0] s);
    int n;
    n = FP_SUM_W;
    for (int i = 0; i < FP_SUM_W; i++) begin
      if (s[i]) n = FP_SUM_W - 1 - i;
    end
    return n;
  endfunction : apm_lzc

  // Main word holds sign/exponent/fraction; in 40-bit form the second word's
  // low byte extends the fraction
  function automatic apm_fp_t apm_fadd(input logic [31:0] a_main, input logic [31:0] a_ext,
                                       input logic [31:0] b_main, input logic [31:0] b_ext,
                                       input logic sub, input logic half,
                                       input logic ext, input logic trunc);
    apm_fp_t           r;
    apm_float_t        fa;
    apm_float_t        fb;
    apm_float_t        res;
    logic              sa, sb, sl, ss, nan_a, nan_b, inf_a, inf_b, g, st, up;
    logic [7:0]        el, es, d;
    logic [30:0]       xa, xb, f31;
    logic [31:0]       ma, mb, ml, ms;
    logic [34:0]       mw, sh;
    logic [35:0]       s, nrm;
    logic [32:0]       kept;
    logic signed [10:0] e;
    int                lz;
    r     = '0;
    fa    = apm_float_t'(a_main);
    fb    = apm_float_t'(b_main);
    xa    = {fa.frac, ext ? a_ext[FP_EXT_W-1:0] : 8'h00};
    xb    = {fb.frac, ext ? b_ext[FP_EXT_W-1:0] : 8'h00};
    sa    = fa.sign;
    sb    = fb.sign ^ sub;
    nan_a = (fa.exp == FP_EXP_MAX) && (xa != '0);
    nan_b = (fb.exp == FP_EXP_MAX) && (xb != '0);
    inf_a = (fa.exp == FP_EXP_MAX) && (xa == '0);
    inf_b = (fb.exp == FP_EXP_MAX) && (xb == '0);
    ma    = (fa.exp == FP_EXP_ZERO) ? '0 : {1'b1, xa};                 // [RQ15]
    mb    = (fb.exp == FP_EXP_ZERO) ? '0 : {1'b1, xb};                 // [RQ15]
    if ({fb.exp, mb} > {fa.exp, ma}) begin
      el = fb.exp; ml = mb; sl = sb; es = fa.exp; ms = ma; ss = sa;
    end else begin
      el = fa.exp; ml = ma; sl = sa; es = fb.exp; ms = mb; ss = sb;
    end
    d     = el - es;
    mw    = {ms, 3'h0};
    sh    = mw >> d;
    // Bits shifted out fold into a sticky bit so rounding sees them
    sh[0] = sh[0] | ((sh << d) != mw);
    s     = (sl == ss) ? ({1'b0, ml, 3'h0} + {1'b0, sh}) : ({1'b0, ml, 3'h0} - {1'b0, sh});
    lz    = apm_lzc(s);
    nrm   = s << lz;
    e     = 11'(el) + 11'sh1 - 11'(lz) - (half ? 11'sh1 : 11'sh0);      // [RQ21]
    if (ext) begin                                                      // [RQ13]
      kept = {1'b0, nrm[35:4]};
      g    = nrm[3];
      st   = |nrm[2:0];
    end else begin
      kept = {9'h000, nrm[35:12]};
      g    = nrm[11];
      st   = |nrm[10:0];
    end
    up   = !trunc && g && (st || kept[0]);                              // [RQ13]
    kept = kept + 33'(up);
    if (ext ? kept[32] : kept[24]) begin
      kept = kept >> 1;
      e    = e + 11'sh1;
    end
    f31  = ext ? kept[30:0] : {kept[22:0], 8'h00};
    res  = '0;
    if (nan_a || nan_b || (inf_a && inf_b && (sa != sb))) begin         // [RQ15] [RQ20]
      r.inv = 1'b1;
      r.w   = '1;
    end else begin
      if (inf_a || inf_b) begin
        res = {inf_a ? sa : sb, FP_EXP_MAX, 23'h000000};
      end else if (s == '0) begin
        res = {sl & ss, FP_EXP_ZERO, 23'h000000};
      end else if (e >= FP_E_OVF) begin                                 // [RQ14] [RQ19]
        r.ovf = 1'b1;
        res   = trunc ? {sl, FP_EXP_LARGEST, 23'h7fffff} : {sl, FP_EXP_MAX, 23'h000000};  // [RQ16]
        if (ext && trunc) r.w[1] = 32'(8'hff);
      end else if (e <= FP_E_MIN) begin                                 // [RQ15] [RQ18]
        r.unf = 1'b1;
        res   = {sl, FP_EXP_ZERO, 23'h000000};
      end else begin
        res = {sl, e[7:0], f31[30:8]};
        if (ext) r.w[1] = 32'(f31[FP_EXT_W-1:0]);
      end
      r.w[0] = res;
      r.zero = (res.exp == FP_EXP_ZERO);                                // [RQ17]
    end
    return r;
  endfunction : apm_fadd

  function automatic apm_result_t apm_exec(input apm_ctrl_t c, input logic [1:0][31:0] a,
                                           input logic [1:0][31:0] b, input apm_stat_t st);
    apm_result_t        r;
    apm_fp_t            f;
    logic [63:0]        av, bv;
    logic [127:0]       wide;
    logic [31:0]        xa, xb, wa, wb, nmask;
    logic [16:0]        nq;
    logic signed [33:0] va, vb, v;
    logic               ovf, uns;
    int                 nw, cnt, w;
    r      = '0;
    r.stat = st;
    wide   = '0;
    ovf    = 1'b0;
    av     = a;
    bv     = b;
    nw     = c.elem_byte ? BYTE_W : SHORT_W;
    uns    = (c.mode == MODE_UNSIGNED_SATURATING_INT);
    case (c.op)
      APM_OP_EXPAND: begin
        cnt   = (c.quad ? DWORD_W : DATA_W) / nw;
        nmask = (32'h1 << nw) - 32'h1;
        for (int i = 0; i < MAX_ELEMS; i++) begin
          if (i < cnt) begin
            xa = 32'(av >> (i * nw)) & nmask;
            xb = 32'(bv >> (i * nw)) & nmask;
            wa = apm_widen(xa, nw, c.mode);
            wb = apm_widen(xb, nw, c.mode);
            if (c.use_rn) wa = c.sub ? (wa - wb) : (wa + wb);
            wide = wide | ((128'(wa) & ((128'h1 << (2 * nw)) - 128'h1)) << (2 * i * nw));
          end
        end
        r.data                       = wide;
        r.stat.zero_flag             = (wide == '0);
        r.stat.sign_flag             = wide[(c.quad ? QUAD_W : DWORD_W) - 1];  // [RQ1]
        r.stat.overflow_flag         = 1'b0;                                    // [RQ1]
        r.stat.carry_flag            = 1'b0;                                    // [RQ1]
      end
      APM_OP_COMPACT: begin
        w     = 2 * nw;                                                 // [RQ4]
        cnt   = DWORD_W / w;
        nmask = (32'h1 << w) - 32'h1;
        for (int i = 0; i < MAX_ELEMS; i++) begin
          if (i < cnt) begin
            xa = 32'(av >> (i * w)) & nmask;
            xb = 32'(bv >> (i * w)) & nmask;
            va = apm_ext34(xa, w, uns);
            vb = apm_ext34(xb, w, uns);
            v  = c.use_rn ? (c.sub ? (va - vb) : (va + vb)) : va;       // [RQ3]
            nq = apm_narrow(v, nw, c.mode, c.trunc);
            ovf  = ovf | nq[16];
            wide = wide | ((128'(nq[15:0]) & ((128'h1 << nw) - 128'h1)) << (i * nw));  // [RQ3]
          end
        end
        r.data                       = wide;
        r.stat.zero_flag             = (wide == '0);
        r.stat.sign_flag             = wide[DATA_W-1];
        r.stat.overflow_flag         = ovf;                             // [RQ11]
        r.stat.sticky_fixed_overflow = st.sticky_fixed_overflow | ovf;
        r.stat.carry_flag            = 1'b0;                            // [RQ11]
      end
      APM_OP_MERGE: begin
        cnt = (c.quad ? DWORD_W : DATA_W) / nw;
        for (int i = 0; i < MAX_ELEMS; i++) begin
          if (i < cnt) begin
            xa   = 32'(av >> (i * nw)) & ((32'h1 << nw) - 32'h1);
            xb   = 32'(bv >> (i * nw)) & ((32'h1 << nw) - 32'h1);
            wide = wide | (128'(xa) << (2 * i * nw)) | (128'(xb) << ((2 * i + 1) * nw));  // [RQ12]
          end
        end
        r.data               = wide;
        r.stat.zero_flag     = (wide == '0);                            // [RQ12]
        r.stat.sign_flag     = wide[(c.quad ? QUAD_W : DWORD_W) - 1];
        r.stat.overflow_flag = 1'b0;
        r.stat.carry_flag    = 1'b0;
      end
      APM_OP_FADD, APM_OP_FHALF: begin
        f = apm_fadd(a[0], a[1], b[0], b[1], c.sub, (c.op == APM_OP_FHALF), c.quad, c.trunc);
        r.data                       = {64'h0, f.w};
        r.stat.zero_flag             = f.zero;                          // [RQ17]
        r.stat.sign_flag             = f.w[0][DATA_W-1];                // [RQ17]
        r.stat.carry_flag            = 1'b0;                            // [RQ17]
        r.stat.overflow_flag         = f.ovf;                           // [RQ19]
        r.stat.sticky_float_overflow = st.sticky_float_overflow | f.ovf;  // [RQ19]
        r.stat.sticky_underflow      = st.sticky_underflow | f.unf;     // [RQ18]
        r.stat.invalid_flag          = f.inv;                           // [RQ20]
        r.stat.sticky_invalid        = st.sticky_invalid | f.inv;       // [RQ20]
      end
      default: r.stat = st;
    endcase
    return r;
  endfunction : apm_exec

  logic                    wr_pend_reg;
  logic                    rd_pend_reg;
  logic [ADDR_W-1:0]       addr_reg;
  logic                    ready_reg;
  logic                    resp_reg;
  logic [31:0]             rdata_reg;
  apm_ctrl_t               ctrl_reg;
  logic [1:0][1:0][31:0]   opa_reg;
  logic [1:0][1:0][31:0]   opb_reg;
  logic [1:0][3:0][31:0]   res_reg;
  apm_stat_t [1:0]         stat_reg;

  logic                    take;
  apm_ctrl_t               ctrl_new;
  apm_dec_t                wdec;
  apm_dec_t                rdec;
  apm_result_t [1:0]       exec_r;
  logic [31:0]             rd_word;

  assign take     = ahb_req.hsel && ahb_req.hready &&
                    ((ahb_req.htrans == HTRANS_NONSEQ) || (ahb_req.htrans == HTRANS_SEQ));
  assign ctrl_new = apm_ctrl_t'(ahb_req.hwdata[CTRL_W-1:0]);
  assign wdec     = apm_decode(addr_reg);
  assign rdec     = wdec;

  // Results are computed from the control word on the bus, so they land at
  // the same edge as the control write and a following read sees them
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      exec_r[b] = apm_exec(ctrl_new, opa_reg[b], opb_reg[b], stat_reg[b]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
      ready_reg   <= 1'b1;
      resp_reg    <= 1'b0;
    end else begin
      wr_pend_reg <= take && ahb_req.hwrite;
      rd_pend_reg <= take && !ahb_req.hwrite;
      // One wait state on reads keeps hrdata a flip-flop
      ready_reg   <= !(take && !ahb_req.hwrite);
      resp_reg    <= 1'b0;
      if (take) addr_reg <= ahb_req.haddr[ADDR_W-1:0];
    end
  end

  always_comb begin
    rd_word = '0;
    if (addr_reg == ADDR_CTRL) begin
      rd_word = 32'(ctrl_reg);
    end else if (rdec.hit) begin
      case (rdec.word)
        WORD_OPA0, WORD_OPA1: rd_word = opa_reg[rdec.blk][rdec.word[0]];
        WORD_OPB0, WORD_OPB1: rd_word = opb_reg[rdec.blk][rdec.word[0]];
        WORD_RES0, WORD_RES1, WORD_RES2, WORD_RES3: rd_word = res_reg[rdec.blk][rdec.word[1:0]];
        WORD_STAT: rd_word = 32'(stat_reg[rdec.blk]);
        default: rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else if (rd_pend_reg) begin
      rdata_reg <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= '0;
    end else if (wr_pend_reg && (addr_reg == ADDR_CTRL)) begin
      ctrl_reg <= ctrl_new;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opa_reg  <= '0;
      opb_reg  <= '0;
      res_reg  <= '0;
      stat_reg <= '0;
    end else if (wr_pend_reg) begin
      if (addr_reg == ADDR_CTRL) begin
        for (int b = 0; b < 2; b++) begin
          if (ctrl_new.blk_sel[b] && (ctrl_new.op != APM_OP_NONE)) begin   // [RQ22]
            res_reg[b]  <= exec_r[b].data;
            stat_reg[b] <= exec_r[b].stat;                                 // [RQ22]
          end
        end
      end else if (wdec.hit) begin
        case (wdec.word)
          WORD_OPA0, WORD_OPA1: opa_reg[wdec.blk][wdec.word[0]] <= ahb_req.hwdata;
          WORD_OPB0, WORD_OPB1: opb_reg[wdec.blk][wdec.word[0]] <= ahb_req.hwdata;
          // Write one to clear; an operation never shares this edge
          WORD_STAT: stat_reg[wdec.blk] <= stat_reg[wdec.blk] &
                                           ~apm_stat_t'(ahb_req.hwdata[STAT_W-1:0]);
          default: ;
        endcase
      end
    end
  end

  assign ahb_rsp.hreadyout = ready_reg;
  assign ahb_rsp.hresp     = resp_reg;
  assign ahb_rsp.hrdata    = rdata_reg;

endmodule : apm_core

/* File: verif/apm_checker.sv */
// Bus and status-word assertions for the pack/merge/float-add slice.
// Assumes the slave is the only one, so hready is its own hreadyout.
module apm_checker
  import apm_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire apm_ahb_req_t ahb_req,
  input wire apm_ahb_rsp_t ahb_rsp
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_dp;
  logic [7:0] dp_addr;
  wire acc  = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  // Status offset 0x20 in any region but 00; region 00 holds the control word
  wire stat = rd_dp & ahb_rsp.hreadyout & (dp_addr[5:0] == 6'h20) & (dp_addr[7:6] != 2'h0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (ahb_req.hready) begin
      rd_dp   <= acc & ~ahb_req.hwrite;
      dp_addr <= ahb_req.haddr[7:0];
    end
  end
  sequence s_wait_data;
    !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
  endsequence
  a_read_wait:    assert property (acc && !ahb_req.hwrite |=> s_wait_data)
    else $error("read data phase did not take exactly one wait");
  a_write_nowait: assert property (acc && ahb_req.hwrite |=> ahb_rsp.hreadyout)
    else $error("write data phase was stalled");
  a_stall_once:   assert property (!ahb_rsp.hreadyout |=> ahb_rsp.hreadyout)
    else $error("wait state longer than one cycle");
  a_resp_okay:    assert property (ahb_rsp.hresp == 1'b0)
    else $error("error response seen");
  a_carry_clear:  assert property (stat |-> !ahb_rsp.hrdata[4])
    else $error("carry flag set in status word");
  a_ovf_sticky:   assert property (stat && ahb_rsp.hrdata[2] |-> ahb_rsp.hrdata[3] || ahb_rsp.hrdata[6])
    else $error("overflow without sticky overflow");
  a_inv_sticky:   assert property (stat && ahb_rsp.hrdata[7] |-> ahb_rsp.hrdata[8])
    else $error("invalid without sticky invalid");
  a_stat_width:   assert property (stat |-> ahb_rsp.hrdata[31:9] == 23'h0)
    else $error("status word upper bits not zero");
endmodule : apm_checker

bind apm_core apm_checker i_chk (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));

/* File: verif/apm_core_test.sv */
// Self-checking bench for the slice, driven as an AHB-Lite master.
// Assumes the slave's hreadyout is fed back as the bus hready.
module apm_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import apm_pkg::*;
  logic         hclk;
  logic         hresetn;
  apm_ahb_req_t req;
  apm_ahb_req_t bus_req;
  apm_ahb_rsp_t rsp;
  int           fail_count;
  int           checked;
  logic [31:0]  r;
  logic [31:0]  s;
  apm_core i_dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(bus_req), .ahb_rsp(rsp));
  always_comb begin
    bus_req        = req;
    bus_req.hready = rsp.hreadyout;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // Waits on hready are bounded so a hung slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 20);
    if (rsp.hreadyout !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    req.hsel   <= 1'b1;
    req.htrans <= HTRANS_NONSEQ;
    req.haddr  <= {24'h0, a};
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    wait_rdy();
    req.htrans <= 2'h0;
    req.hwdata <= d;
    wait_rdy();
    q = rsp.hrdata;
  endtask : xfer
  // Loads both operand pairs, runs one op, returns RES0 and the status word
  task automatic op(input logic [7:0] b, input logic [31:0] a0, a1, b0, c,
                    output logic [31:0] res, output logic [31:0] st);
    logic [31:0] q;
    xfer(1'b1, b, a0, q);
    xfer(1'b1, b + 8'h04, a1, q);
    xfer(1'b1, b + 8'h08, b0, q);
    xfer(1'b1, b + 8'h0c, 32'h0, q);
    xfer(1'b1, 8'h00, c, q);
    xfer(1'b0, b + 8'h10, 32'h0, res);
    xfer(1'b0, b + 8'h20, 32'h0, st);
  endtask : op
  task automatic t_sat();
    xfer(1'b1, 8'h60, 32'h1ff, r);
    op(8'h40, 32'h00012345, 32'hfffe0000, 0, 32'h412, r, s);
    chk("sat_res", r, 32'h80007fff);
    chk("sat_st", s & 32'h1e, 32'h0e);
    op(8'h40, 32'h01000012, 32'h00ff0034, 0, 32'h43a, r, s);
    chk("usat_res", r, 32'hff34ff12);
    chk("usat_st", s & 32'h14, 32'h04);
    $display("test sat done");
  endtask : t_sat
  task automatic t_wrap();
    op(8'h40, 32'h00018000, 32'h0, 0, 32'h40a, r, s);
    chk("wrap_res", r, 32'h00008000);
    chk("wrap_st", s & 32'h14, 32'h04);
    op(8'h40, 32'h12358000, 32'h7fff8000, 0, 32'h402, r, s);
    chk("frac_rnd", r, 32'h7fff1236);
    op(8'h40, 32'h12358000, 32'h7fff8000, 0, 32'h602, r, s);
    chk("frac_trn", r, 32'h7fff1235);
    op(8'h40, 32'h00020001, 32'h0, 32'h00010002, 32'h502, r, s);
    chk("frac_add", r, 32'h00000003);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_merge();
    op(8'h40, 32'h44332211, 0, 32'h88776655, 32'h423, r, s);
    chk("mrg_res", r, 32'h66225511);
    op(8'h40, 0, 0, 0, 32'h423, r, s);
    chk("mrg_zero", s & 32'h1, 32'h1);
    op(8'h40, 32'h800000ff, 0, 0, 32'h431, r, s);
    chk("exp_sgn", r, 32'h0000ffff);
    chk("exp_st", s & 32'h1e, 32'h0a);
    op(8'h40, 32'h800000ff, 0, 0, 32'h421, r, s);
    chk("exp_frac", r, 32'h0000ff00);
    op(8'h40, 32'h800000ff, 0, 0, 32'h439, r, s);
    chk("exp_uns", r, 32'h000000ff);
    $display("test merge done");
  endtask : t_merge
  task automatic t_float();
    xfer(1'b1, 8'h60, 32'h1ff, r);
    op(8'h40, 32'h3f800000, 0, 32'h3f800000, 32'h404, r, s);
    chk("f_add", r, 32'h40000000);
    chk("f_add_st", s & 32'h1f, 32'h0);
    op(8'h40, 32'h3f800000, 0, 32'h3f800000, 32'h405, r, s);
    chk("f_half", r, 32'h3f800000);
    op(8'h40, 32'h7f7fffff, 0, 32'h7f7fffff, 32'h404, r, s);
    chk("f_ovf", r, 32'h7f800000);
    chk("f_ovf_st", s & 32'h54, 32'h44);
    op(8'h40, 32'h7f7fffff, 0, 32'h7f7fffff, 32'h604, r, s);
    chk("f_ovf_t", r, 32'h7f7fffff);
    op(8'h40, 32'h7fc00000, 0, 32'h3f800000, 32'h404, r, s);
    chk("f_nan", r, 32'hffffffff);
    chk("f_nan_st", s & 32'h180, 32'h180);
    op(8'h40, 32'h00c00000, 0, 32'h00800000, 32'h484, r, s);
    chk("f_den", r, 32'h0);
    chk("f_den_st", s & 32'h21, 32'h21);
    op(8'h40, 32'h3f800000, 0, 32'h3f800000, 32'h404, r, s);
    chk("f_keep", s & 32'h21, 32'h20);
    op(8'h80, 32'h3f800000, 0, 32'h3f800000, 32'h804, r, s);
    chk("y_res", r, 32'h40000000);
    chk("y_st", s & 32'h1a0, 32'h0);
    $display("test float done");
  endtask : t_float
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    fail_count = 0;
    checked    = 0;
    req        = '0;
    hresetn    = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_sat();
    t_wrap();
    t_merge();
    t_float();
    end_of_test();
  end
endmodule : apm_core_test
